// ### pkg/lock_pkg.sv
// Purpose: Constants, types and lookups for the current lock fault block
// Assumes: 200 MHz system clock, 0.1 ms filter and retry time base
// Notes:   Timing tables are counted in 0.1 ms ticks
package lock_pkg;
    localparam int CLK_MHZ = 200;
    localparam int TICK_US = 100;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    // Register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_STS = 8'h04;
    localparam logic [7:0] OFS_CLR = 8'h08;
    localparam logic [7:0] OFS_IEN = 8'h0c;
    localparam logic [7:0] OFS_CTL = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    // Field positions in fault_settings_one
    localparam int THR_LSB = 19;
    localparam int MODE_LSB = 15;
    localparam int DEG_LSB = 11;
    localparam int RTY_LSB = 7;
    // Status bits
    localparam int STS_W = 3;
    localparam int ST_EVT = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_RETRY = 2;

    typedef enum logic [1:0] {
        FS_IDLE   = 2'b00,
        FS_RETRY  = 2'b01,
        FS_LATCH  = 2'b11,
        FS_REPORT = 2'b10
    } fsm_t;

    typedef struct packed {
        logic hiz;
        logic ls_on;
        logic hs_on;
    } bridge_cmd_t;

    function automatic logic [13:0] thr_ma(input logic [3:0] c);
        case (c)
            4'h0: thr_ma = 14'd125;
            4'h1: thr_ma = 14'd250;
            4'h2: thr_ma = 14'd500;
            4'hE: thr_ma = 14'd7000;
            4'hF: thr_ma = 14'd8000;
            // Codes 3 to 13 run from 1000 mA in 500 mA steps
            default: thr_ma = 14'(({10'd0, c} - 14'd1) * 14'd500);
        endcase
    endfunction

    function automatic logic [13:0] deg_ticks(input logic [3:0] c);
        case (c)
            4'h0: deg_ticks = 14'd0;
            4'h1: deg_ticks = 14'd1;
            4'h2: deg_ticks = 14'd2;
            4'h3: deg_ticks = 14'd5;
            4'h4: deg_ticks = 14'd10;
            4'h5: deg_ticks = 14'd25;
            4'h6: deg_ticks = 14'd50;
            4'h7: deg_ticks = 14'd75;
            4'h8: deg_ticks = 14'd100;
            4'h9: deg_ticks = 14'd250;
            4'hA: deg_ticks = 14'd500;
            4'hB: deg_ticks = 14'd750;
            4'hC: deg_ticks = 14'd1000;
            4'hD: deg_ticks = 14'd2000;
            4'hE: deg_ticks = 14'd5000;
            default: deg_ticks = 14'd10000;
        endcase
    endfunction

    function automatic logic [17:0] retry_ticks(input logic [3:0] c);
        case (c)
            4'h0: retry_ticks = 18'd3000;
            4'h1: retry_ticks = 18'd5000;
            default: retry_ticks = 18'(({14'd0, c} - 18'd1) * 18'd10000);
        endcase
    endfunction

    function automatic bridge_cmd_t act_of(input logic [2:0] m);
        case (m)
            3'd0, 3'd3: act_of = '{hiz: 1'b1, ls_on: 1'b0, hs_on: 1'b0};
            3'd1, 3'd4: act_of = '{hiz: 1'b0, ls_on: 1'b1, hs_on: 1'b0};
            3'd2, 3'd5: act_of = '{hiz: 1'b0, ls_on: 1'b0, hs_on: 1'b1};
            default:    act_of = '0;
        endcase
    endfunction
endpackage

// ### rtl/current_lock_fault_response.sv
// Purpose: Current lock deglitch and fault response with APB registers
// Assumes: meas_current_i in mA, synchronous to clk_sys_i
// Notes:   Retry limit comes from the retry_count_limit_i input port
//
// Summary of operation
// - Three-bit response selector, read/write, resets to zero, eight reactions.
// - Selector 0 latches fault, asserts indicator, tristates all half-bridges.
// - Selector 1 latches fault, asserts indicator, turns on all low sides.
// - Selector 2 latches fault, asserts indicator, turns on all high sides.
// - Selector 3 auto-retries after delay; beyond limit latches with tristate.
// - Selector 4 low-side brakes, asserts indicator, auto-retries up to limit.
// - Selector 5 auto-retries; beyond limit latches with high-side brake.
// - Selector 6 only asserts the indicator; output stage unchanged.
// - Selector 7 disables detection: no fault, indicator or action.
// - Four-bit filter time, zero means none, codes 1-15 from 0.1-1000 ms.
// - Four-bit retry delay: 300 ms, 500 ms, then 1 s to 14 s.
// - Four-bit current threshold from 0.125 A to 8.0 A against measured current.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module current_lock_fault_response #(
    parameter int TICK_CYCLES = lock_pkg::TICK_CYC,
    parameter int CNT_W       = 8
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 nrst_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [7:0]           paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic [31:0]               prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire logic [13:0]          meas_current_i,
    input  wire logic [CNT_W-1:0]     retry_count_limit_i,
    output lock_pkg::bridge_cmd_t     bridge_o,
    output logic                      fault_indicator_n_o,
    output logic                      irq_o
);
    import lock_pkg::*;

    typedef struct packed {
        fsm_t              fsm;
        logic [15:0]       tick_cnt;
        logic [13:0]       deg_cnt;
        logic              armed;
        logic [17:0]       retry_tmr;
        logic [CNT_W-1:0]  retry_cnt;
        bridge_cmd_t       act;
        logic              fault_n;
        logic [31:0]       cfg;
        logic [STS_W-1:0]  sts;
        logic [STS_W-1:0]  ien;
        logic [31:0]       prdata;
    } state_t;

    state_t      s;
    state_t      next_s;
    logic        tick;
    logic        above;
    logic        lock_evt;
    logic        wr;
    logic        setup;
    logic        sw_clear;
    logic        mapped;
    logic [2:0]  mode;
    logic [STS_W-1:0] sts_set;
    logic [STS_W-1:0] sts_clr;

    assign mode     = s.cfg[MODE_LSB+:3];
    assign setup    = psel_i && !penable_i;
    assign wr       = psel_i && penable_i && pwrite_i;
    assign sw_clear = wr && paddr_i == OFS_CTL && pwdata_i[0];
    assign mapped   = paddr_i inside {OFS_CFG, OFS_STS, OFS_CLR,
                                      OFS_IEN, OFS_CTL, OFS_STATE};
    assign tick     = s.tick_cnt == 16'(TICK_CYCLES - 1);
    // Threshold compare on the raw ADC value in mA
    assign above    = meas_current_i > thr_ma(s.cfg[THR_LSB+:4]);

    always_comb begin
        next_s   = s;
        lock_evt = 1'b0;
        sts_set  = '0;
        sts_clr  = '0;
        next_s.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;

        // Deglitch: one event per continuous overcurrent episode
        if (!above) begin
            next_s.deg_cnt = 14'h0000;
            next_s.armed   = 1'b1;
        end else if (s.armed) begin
            if (s.deg_cnt >= deg_ticks(s.cfg[DEG_LSB+:4])) begin
                lock_evt       = 1'b1;
                next_s.armed   = 1'b0;
                next_s.deg_cnt = 14'h0000;
            end else if (tick) begin
                next_s.deg_cnt = s.deg_cnt + 14'h0001;
            end
        end

        if (sw_clear) begin
            next_s.retry_cnt = '0;
        end

        case (s.fsm)
            FS_IDLE: begin
                if (lock_evt) begin
                    case (mode)
                        3'd0, 3'd1, 3'd2: begin
                            next_s.fsm = FS_LATCH;
                            next_s.act = act_of(mode);
                            sts_set[ST_LATCH] = 1'b1;
                        end
                        3'd3, 3'd4, 3'd5: begin
                            next_s.act = act_of(mode);
                            if (s.retry_cnt >= retry_count_limit_i) begin
                                next_s.fsm = FS_LATCH;
                                sts_set[ST_LATCH] = 1'b1;
                            end else begin
                                next_s.fsm       = FS_RETRY;
                                next_s.retry_tmr = 18'h0_0000;
                                next_s.retry_cnt = s.retry_cnt + 1'b1;
                                sts_set[ST_RETRY] = 1'b1;
                            end
                        end
                        3'd6: begin
                            next_s.fsm = FS_REPORT;
                        end
                        default: begin
                            next_s.fsm = FS_IDLE;
                        end
                    endcase
                    sts_set[ST_EVT] = mode != 3'd7;
                end
            end
            FS_RETRY: begin
                // Retry delay set by the code as read in every clock cycle
                if (s.retry_tmr >= retry_ticks(s.cfg[RTY_LSB+:4])) begin
                    next_s.fsm = FS_IDLE;
                    next_s.act = '0;
                end else if (tick) begin
                    next_s.retry_tmr = s.retry_tmr + 18'h0_0001;
                end
            end
            FS_LATCH, FS_REPORT: begin
                if (sw_clear) begin
                    next_s.fsm = FS_IDLE;
                    next_s.act = '0;
                end
            end
            default: begin
                next_s.fsm = FS_IDLE;
                next_s.act = '0;
            end
        endcase
        next_s.fault_n = next_s.fsm == FS_IDLE;

        // APB register side
        if (wr && paddr_i == OFS_CFG) begin
            next_s.cfg = pwdata_i;
        end
        if (wr && paddr_i == OFS_IEN) begin
            next_s.ien = pwdata_i[STS_W-1:0];
        end
        if (wr && paddr_i == OFS_CLR) begin
            sts_clr = pwdata_i[STS_W-1:0];
        end
        // A new event outweighs a clear in the same cycle
        next_s.sts = (s.sts & ~sts_clr) | sts_set;

        if (setup) begin
            case (paddr_i)
                OFS_CFG:   next_s.prdata = s.cfg;
                OFS_STS:   next_s.prdata = {29'h0, s.sts};
                OFS_IEN:   next_s.prdata = {29'h0, s.ien};
                OFS_STATE: next_s.prdata = {16'h0000, 8'(s.retry_cnt),
                                            5'h00, s.fault_n, s.fsm};
                default:   next_s.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            s         <= '0;
            s.fsm     <= FS_IDLE;
            s.armed   <= 1'b1;
            s.fault_n <= 1'b1;
            s.cfg     <= CFG_RST;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_o            = s.prdata;
    assign pready_o            = 1'b1;
    assign pslverr_o           = psel_i && penable_i && !mapped;
    assign bridge_o            = s.act;
    assign fault_indicator_n_o = s.fault_n;
    assign irq_o               = |(s.sts & s.ien);

    default clocking dc @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    a_mode_reset: assert property ($rose(nrst_i) |-> mode == 3'd0)
        else $error("selector not zero after reset");
    a_latch_tristate: assert property (
        s.fsm == FS_IDLE && lock_evt && mode == 3'd0
        |=> s.fsm == FS_LATCH && s.act.hiz && !fault_indicator_n_o)
        else $error("mode 0 did not latch tristated");
    a_latch_low_brake: assert property (
        s.fsm == FS_IDLE && lock_evt && mode == 3'd1
        |=> s.act.ls_on && !s.act.hs_on && !fault_indicator_n_o)
        else $error("mode 1 did not low-side brake");
    a_latch_high_brake: assert property (
        s.fsm == FS_IDLE && lock_evt && mode == 3'd2
        |=> s.act.hs_on && !s.act.ls_on && s.fsm == FS_LATCH)
        else $error("mode 2 did not high-side brake");
    a_retry_count: assert property (
        s.fsm == FS_IDLE && lock_evt && mode == 3'd3 && !sw_clear
        && s.retry_cnt < retry_count_limit_i
        |=> s.fsm == FS_RETRY && s.retry_cnt == $past(s.retry_cnt) + 1'b1)
        else $error("retry not counted");
    a_retry_low_brake: assert property (
        s.fsm == FS_IDLE && lock_evt && mode == 3'd4
        |=> s.act.ls_on && !fault_indicator_n_o)
        else $error("mode 4 brake missing");
    a_retry_exhausted: assert property (
        s.fsm == FS_IDLE && lock_evt && mode == 3'd5 && !sw_clear
        && s.retry_cnt >= retry_count_limit_i
        |=> s.fsm == FS_LATCH && s.act.hs_on)
        else $error("mode 5 did not latch after retries");
    a_report_only: assert property (
        s.fsm == FS_IDLE && lock_evt && mode == 3'd6
        |=> s.fsm == FS_REPORT && s.act == '0 && !fault_indicator_n_o)
        else $error("report mode changed outputs");
    a_lock_disabled: assert property (
        s.fsm == FS_IDLE && lock_evt && mode == 3'd7
        |=> fault_indicator_n_o && s.act == '0 && !s.sts[ST_EVT] [*1])
        else $error("disabled mode raised a fault");
    a_filter_zero: assert property (
        s.cfg[DEG_LSB+:4] == 4'h0 && above && s.armed |-> lock_evt)
        else $error("zero filter time delayed event");
    a_filter_hold: assert property (lock_evt |-> above ##0
        s.deg_cnt == deg_ticks(s.cfg[DEG_LSB+:4]))
        else $error("event before filter time elapsed");
    a_clear_retries: assert property (sw_clear |=> s.retry_cnt == '0)
        else $error("retry counter not cleared");

    c_retry_cycle: cover property (s.fsm == FS_RETRY ##1 s.fsm == FS_IDLE);
    c_latched: cover property (s.fsm == FS_LATCH ##1 s.fsm == FS_IDLE);
    c_report: cover property (s.fsm == FS_REPORT);
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for the current lock fault response block
// Assumes: Short tick of 4 clocks; expectations come from bench tables
// Notes:   Retry delay code 0 keeps the auto-retry walk near 12000 cycles
`timescale 1ns/1ps
module tb;
    import lock_pkg::*;
    localparam int TK = 4;
    logic            clk_sys_i = 1'b0;
    logic            nrst_i = 1'b0;
    logic            psel = 1'b0;
    logic            pen = 1'b0;
    logic            pwr = 1'b0;
    logic [7:0]      padr = 8'h00;
    logic [31:0]     pwd = 32'h0000_0000;
    logic [31:0]     prd;
    logic            prdy;
    logic            perr;
    logic            ind_n;
    logic            irq;
    bridge_cmd_t     br;
    logic [13:0]     cur = 14'h0000;
    logic [7:0]      lim = 8'h00;
    logic [31:0]     rd;
    logic [31:0]     wv;
    logic            er;
    int              n_fail = 0;
    int              compares = 0;
    int              cyc = 0;
    int              n;
    int              m;
    int              t;
    int              deg_m [16] = '{0, 1, 2, 5, 10, 25, 50, 75, 100, 250,
                                    500, 750, 1000, 2000, 5000, 10000};

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, a, b); end end

    always #2.5 clk_sys_i = ~clk_sys_i;

    current_lock_fault_response #(.TICK_CYCLES(TK), .CNT_W(8)) i_dut (
        .clk_sys_i          (clk_sys_i),
        .nrst_i             (nrst_i),
        .psel_i             (psel),
        .penable_i          (pen),
        .pwrite_i           (pwr),
        .paddr_i            (padr),
        .pwdata_i           (pwd),
        .prdata_o           (prd),
        .pready_o           (prdy),
        .pslverr_o          (perr),
        .meas_current_i     (cur),
        .retry_count_limit_i(lim),
        .bridge_o           (br),
        .fault_indicator_n_o(ind_n),
        .irq_o              (irq)
    );

    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Ceiling well above the longest walk, the auto-retry delay
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            $display("unexpected at %0t: timeout", $time);
            print_verdict();
        end
    end

    function automatic int thr_m(int c);
        if (c < 3) return 125 << c;
        if (c < 14) return 1000 + (c - 3) * 500;
        return (c == 14) ? 7000 : 8000;
    endfunction

    function automatic logic [2:0] act_m(int md);
        return (md > 5) ? 3'b000 : 3'b100 >> (md % 3);
    endfunction

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk_sys_i);
        pen <= 1'b1;
        do @(posedge clk_sys_i); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic cfg(int thr, int md, int dg);
        apb(1'b1, OFS_CFG, (thr << THR_LSB) | (md << MODE_LSB)
            | (dg << DEG_LSB));
    endtask

    task automatic drive(int v);
        @(posedge clk_sys_i);
        cur <= 14'(v);
    endtask

    task automatic wait_lvl(logic v, int max);
        n = 0;
        while (ind_n !== v && n < max) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
    endtask

    // Current must drop first, otherwise the same episode cannot rearm
    task automatic clear_all();
        drive(0);
        apb(1'b1, OFS_CTL, 32'h0000_0001);
        apb(1'b1, OFS_CLR, 32'h0000_0007);
        repeat (3) @(posedge clk_sys_i);
        #1;
        `CHK(ind_n, 1'b1)
    endtask

    initial begin
        void'($urandom(71));
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        apb(1'b0, OFS_CFG, 32'h0000_0000);
        `CHK(rd, CFG_RST)
        apb(1'b0, 8'h40, 32'h0000_0000);
        `CHK(er, 1'b1)
        repeat (4) begin
            wv = $urandom;
            apb(1'b1, OFS_CFG, wv);
            apb(1'b0, OFS_CFG, 32'h0000_0000);
            `CHK(rd, wv)
        end
        apb(1'b1, OFS_IEN, 32'h0000_0007);
        for (m = 0; m < 8; m++) begin
            t = $urandom_range(15);
            cfg(t, m, 0);
            drive(thr_m(t));
            repeat (5) @(posedge clk_sys_i);
            #1;
            `CHK(ind_n, 1'b1)
            drive(thr_m(t) + 1);
            wait_lvl(1'b0, 10);
            repeat (3) @(posedge clk_sys_i);
            #1;
            `CHK(ind_n, 1'(m == 7))
            `CHK(3'(br), act_m(m))
            `CHK(irq, 1'(m != 7))
            apb(1'b0, OFS_STATE, 32'h0000_0000);
            `CHK(rd[1:0], (m < 6) ? 2'b11 : (m == 6) ? 2'b10 : 2'b00)
            clear_all();
        end
        // Short glitches must not complete the filter count
        cfg(2, 0, 3);
        repeat (3) begin
            drive(thr_m(2) + 1);
            repeat ((deg_m[3] - 1) * TK - 2) @(posedge clk_sys_i);
            drive(0);
        end
        #1;
        `CHK(ind_n, 1'b1)
        drive(thr_m(2) + 1);
        wait_lvl(1'b0, 100);
        `CHK(n >= (deg_m[3] - 1) * TK && n <= (deg_m[3] + 1) * TK + 4, 1'b1)
        clear_all();
        // Masked event, then enable and clear the sticky status
        apb(1'b1, OFS_IEN, 32'h0000_0000);
        cfg(1, 6, 0);
        drive(thr_m(1) + 1);
        wait_lvl(1'b0, 10);
        apb(1'b0, OFS_STS, 32'h0000_0000);
        `CHK(rd[ST_EVT], 1'b1)
        `CHK(irq, 1'b0)
        apb(1'b1, OFS_IEN, 32'h0000_0007);
        @(posedge clk_sys_i);
        #1;
        `CHK(irq, 1'b1)
        apb(1'b1, OFS_CLR, 32'h0000_0007);
        @(posedge clk_sys_i);
        #1;
        `CHK(irq, 1'b0)
        clear_all();
        // Auto-retry with a limit of one, then latch
        @(posedge clk_sys_i);
        lim <= 8'h01;
        cfg(1, 3, 0);
        drive(thr_m(1) + 1);
        wait_lvl(1'b0, 10);
        drive(0);
        repeat (2) @(posedge clk_sys_i);
        #1;
        `CHK(3'(br), 3'b100)
        wait_lvl(1'b1, 3002 * TK);
        `CHK(n > 2990 * TK && n <= 3002 * TK, 1'b1)
        apb(1'b0, OFS_STATE, 32'h0000_0000);
        `CHK(rd[15:8], 8'h01)
        drive(thr_m(1) + 1);
        wait_lvl(1'b0, 10);
        repeat (2) @(posedge clk_sys_i);
        apb(1'b0, OFS_STATE, 32'h0000_0000);
        `CHK(rd[1:0], 2'b11)
        clear_all();
        apb(1'b0, OFS_STATE, 32'h0000_0000);
        `CHK(rd[15:8], 8'h00)
        // Mode 4 under the limit brakes low while it waits to retry
        cfg(1, 4, 0);
        drive(thr_m(1) + 1);
        wait_lvl(1'b0, 10);
        drive(0);
        apb(1'b0, OFS_STATE, 32'h0000_0000);
        `CHK(rd[1:0], 2'b01)
        `CHK(3'(br), 3'b010)
        wait_lvl(1'b1, 3002 * TK);
        `CHK(ind_n, 1'b1)
        print_verdict();
    end
endmodule
